// File: inc/rps_defines.vh
// Constants for the reset pin sequencer.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RPS_DEFINES_VH
`define RPS_DEFINES_VH

// ----------------------------------------------------------------------
// Soft reset pin drive timing
// ----------------------------------------------------------------------
`define RPS_SOFT_DRIVE_CYCLES 6
`define RPS_CNT_W 4

// ----------------------------------------------------------------------
// Power-on style reset stretch after hardware pin release
// ----------------------------------------------------------------------
`define RPS_POR_STRETCH_CYCLES 16

// ----------------------------------------------------------------------
// Soft reset pin sense window after release (two sync flops plus one)
// ----------------------------------------------------------------------
`define RPS_SENSE_CYCLES 3

// ----------------------------------------------------------------------
// Synchroniser levels while in reset
// ----------------------------------------------------------------------
`define RPS_SYNC_HW_INIT 1'b0
`define RPS_SYNC_SOFT_INIT 1'b1

`endif

// File: tb/rps_monitor.sv
// Port checks of the reset pin sequencer, bound into the design.
// Assumes clk_en stays high while the checks run.
`timescale 1ns/100ps
module rps_monitor #(parameter DRIVE_CYCLES = 6, POR_CYCLES = 16) (
  input wire ref_clk, reset, clk_en, hw_reset_pad_n, soft_reset_pad_in,
  input wire soft_reset_pad_out, soft_reset_pad_oe, por_reset, core_reset,
  input wire run_enable, soft_reset_active);
  reg [3:0] n;
  // Edges from a sampled pad rise to the last edge with run low
  localparam int RUN_PRE = POR_CYCLES + 2;
  // Length of the current drive burst
  always @(posedge ref_clk) n <= soft_reset_pad_oe && !reset ? n + 4'h1 : 4'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_hw_hold:
    assert property (!hw_reset_pad_n [*4] |=> por_reset) else $error("hold");
  a_por_stretch:
    assert property ($rose(hw_reset_pad_n) |-> por_reset [*4]) else $error("por");
  a_run_after:
    assert property ($rose(hw_reset_pad_n) |->
    ##RUN_PRE !run_enable ##1 run_enable) else $error("run");
  a_soft_hold:
    assert property (soft_reset_active |-> core_reset && !run_enable)
    else $error("soft");
  a_soft_spare:
    assert property (soft_reset_active |-> !por_reset) else $error("spare");
  a_pad_drive:
    assert property (run_enable && !soft_reset_pad_in ##1 !soft_reset_pad_in [*3]
    |=> soft_reset_pad_oe && !soft_reset_pad_out) else $error("drive");
  a_drive_len:
    assert property ($fell(soft_reset_pad_oe) |-> n == DRIVE_CYCLES)
    else $error("len");
  a_pad_resense:
    assert property ($fell(soft_reset_pad_oe) ##0 !soft_reset_pad_in [*3]
    |=> ##[0:2] soft_reset_pad_oe) else $error("resense");
  a_soft_release:
    assert property ($fell(soft_reset_pad_oe) ##0 soft_reset_pad_in [*3]
    |-> ##[1:4] !core_reset) else $error("release");
endmodule
bind rps_sequencer rps_monitor #(.DRIVE_CYCLES(DRIVE_CYCLES),
  .POR_CYCLES(POR_CYCLES)) mon_u (.*);

// File: tb/rps_reset_source.sv
// Board reset source with the pull-up of the soft reset pad.
// Assumes its task is called just after a falling clock edge.
`timescale 1ns/100ps
module rps_reset_source (
  input wire oe,
  input wire out,
  output reg hw_n = 1'b0,
  output wire pad
);
  reg soft_low = 1'b0;
  // Open drain pad, pulled high when nobody drives it
  assign pad = !((oe && !out) || soft_low);
  // Pad requests of the board
  task set(input reg hw, input reg sl);
    hw_n = hw;
    soft_low = sl;
  endtask
endmodule

// File: tb/testbench.sv
// Testbench: reset sequencer against the board reset source model.
// Assumes checker and source model are compiled before it.
`timescale 1ns/100ps
module testbench;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  integer n_errors = 0, tests_run = 0, cyc = 0, k;
  wire hw_n, pad, out, oe, por, core, run, act;
  // Clock of 8 ns
  always #4 ref_clk = ~ref_clk;
  rps_sequencer #(.POR_CYCLES(2)) dut_u (.ref_clk, .reset, .clk_en(1'b1),
    .hw_reset_pad_n(hw_n), .soft_reset_pad_in(pad), .soft_reset_pad_out(out),
    .soft_reset_pad_oe(oe), .por_reset(por), .core_reset(core),
    .run_enable(run), .soft_reset_active(act));
  rps_reset_source src_u (.oe, .out, .hw_n, .pad);
  task wt(input integer c);
    repeat (c) @(negedge ref_clk);
  endtask
  task chk(input reg a, input reg e);
    tests_run++;
    if (a !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, a, e);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hardware pad held low, released, stretched, then run
  task t_hw;
    src_u.set(1'b0, 1'b0);
    wt(6);
    chk(por, 1'b1);
    chk(run, 1'b0);
    src_u.set(1'b1, 1'b0);
    wt(4);
    chk(por, 1'b1);
    for (k = 0; k < 20 && run !== 1'b1; k++) wt(1);
    chk(por, 1'b0);
    chk(run, 1'b1);
  endtask
  // Soft pad held until a second burst starts, then released
  task t_soft;
    src_u.set(1'b1, 1'b1);
    for (k = 0; k < 10 && oe !== 1'b1; k++) wt(1);
    chk(out, 1'b0);
    chk(core, 1'b1);
    chk(por, 1'b0);
    for (k = 0; k < 10 && oe === 1'b1; k++) wt(1);
    chk(k == 6, 1'b1);
    for (k = 0; k < 10 && oe !== 1'b1; k++) wt(1);
    chk(oe, 1'b1);
    src_u.set(1'b1, 1'b0);
    for (k = 0; k < 30 && run !== 1'b1; k++) wt(1);
    chk(core, 1'b0);
    chk(act, 1'b0);
  endtask
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      final_report;
    end
  end
  // Reset, then the scenarios
  initial begin
    wt(3);
    reset = 1'b0;
    t_hw;
    t_soft;
    t_hw;
    final_report;
  end
endmodule

// File: verilog/rps_sequencer.v
// Reset pin sequencer: handles the hardware and soft reset pins.
// Assumes one clock ref_clk, synchronous reset, pins asynchronous.
`timescale 1ns/100ps
`include "rps_defines.vh"

module rps_sequencer #(
  parameter DRIVE_CYCLES = `RPS_SOFT_DRIVE_CYCLES,
  parameter POR_CYCLES = `RPS_POR_STRETCH_CYCLES
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire hw_reset_pad_n,
  input wire soft_reset_pad_in,
  output reg soft_reset_pad_out,
  output reg soft_reset_pad_oe,
  output reg por_reset,
  output reg core_reset,
  output reg run_enable,
  output reg soft_reset_active
);

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  wire hw_n_sync;
  wire soft_n_sync;

  // Both pads cross into ref_clk before any logic
  // Hardware sync starts asserted: no false stretch out of reset
  rps_sync2 #(
    .RESET_VAL(`RPS_SYNC_HW_INIT)
  ) u_sync_hw (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(hw_reset_pad_n),
    .sync_out(hw_n_sync)
  );

  rps_sync2 #(
    .RESET_VAL(`RPS_SYNC_SOFT_INIT)
  ) u_sync_soft (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(soft_reset_pad_in),
    .sync_out(soft_n_sync)
  );

  // ------------------------------------------------------------------
  // State and counters
  // ------------------------------------------------------------------
  // Counter end values, cut to the counter widths on purpose
  localparam CW = `RPS_CNT_W;
  localparam PW = `RPS_CNT_W + 2;
  localparam integer DRIVE_END = DRIVE_CYCLES - 1;
  localparam integer POR_END = POR_CYCLES - 1;
  localparam integer SENSE_END = `RPS_SENSE_CYCLES - 1;
  localparam [CW-1:0] DRIVE_LAST = DRIVE_END[CW-1:0];
  localparam [PW-1:0] POR_LAST = POR_END[PW-1:0];
  localparam [CW-1:0] SENSE_LAST = SENSE_END[CW-1:0];
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
  localparam [PW-1:0] POR_ONE = {{(PW-1){1'b0}}, 1'b1};

  // Sequencer states
  localparam [2:0] ST_HOLD = 3'h0; // Hardware pad held low
  localparam [2:0] ST_POR = 3'h1; // Power-on stretch
  localparam [2:0] ST_RUN = 3'h2; // Core may execute
  localparam [2:0] ST_DRIVE = 3'h3; // Soft pad driven low
  localparam [2:0] ST_SENSE = 3'h4; // Soft pad released, resampled
  localparam [2:0] ST_SOFT = 3'h5; // Soft pad seen high

  reg [2:0] state;
  reg [2:0] next_state;
  reg [CW-1:0] drive_cnt;
  reg [CW-1:0] next_drive_cnt;
  reg [PW-1:0] por_cnt;
  reg [PW-1:0] next_por_cnt;

  // ------------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------------
  // Next state decision
  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (hw_n_sync)
          next_state = ST_POR;
      end
      ST_POR: begin
        if (por_cnt == POR_LAST)
          next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!soft_n_sync)
          next_state = ST_DRIVE;
      end
      ST_DRIVE: begin
        if (drive_cnt == DRIVE_LAST)
          next_state = ST_SENSE;
      end
      ST_SENSE: begin
        // Released pin needs the sync delay before a fair sample
        if (drive_cnt == SENSE_LAST) begin
          if (soft_n_sync)
            next_state = ST_SOFT;
          else
            next_state = ST_DRIVE;
        end
      end
      ST_SOFT: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
    // Hardware pin low overrides everything
    if (!hw_n_sync)
      next_state = ST_HOLD;
  end

  // Counter next values; the drive counter only runs in the soft loop
  always @* begin
    next_drive_cnt = {CW{1'b0}};
    if (next_state == state && (state == ST_DRIVE || state == ST_SENSE))
      next_drive_cnt = drive_cnt + CNT_ONE;
    next_por_cnt = {PW{1'b0}};
    if (state == ST_POR)
      next_por_cnt = por_cnt + POR_ONE;
  end

  // State register and counters
  always @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_HOLD;
      drive_cnt <= {CW{1'b0}};
      por_cnt <= {PW{1'b0}};
    end else if (clk_en) begin
      state <= next_state;
      drive_cnt <= next_drive_cnt;
      por_cnt <= next_por_cnt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  reg next_por_reset;
  reg next_core_reset;
  reg next_run_enable;
  reg next_soft_active;
  reg next_pad_oe;

  // Reset controls for the coming state; decoded ahead so outputs are flops
  always @* begin
    next_por_reset = 1'b0;
    next_core_reset = 1'b1;
    next_run_enable = 1'b0;
    next_soft_active = 1'b0;
    next_pad_oe = 1'b0;
    case (next_state)
      ST_HOLD: begin
        next_por_reset = 1'b1;
      end
      ST_POR: begin
        next_por_reset = 1'b1;
      end
      ST_RUN: begin
        next_core_reset = 1'b0;
        next_run_enable = 1'b1;
      end
      ST_DRIVE: begin
        next_soft_active = 1'b1;
        next_pad_oe = 1'b1;
      end
      ST_SENSE: begin
        next_soft_active = 1'b1;
      end
      ST_SOFT: begin
        next_soft_active = 1'b1;
      end
      default: begin
        next_por_reset = 1'b1;
      end
    endcase
  end

  // Registered reset controls and pad drive
  always @(posedge ref_clk) begin
    if (reset) begin
      por_reset <= 1'b1;
      core_reset <= 1'b1;
      run_enable <= 1'b0;
      soft_reset_active <= 1'b0;
      soft_reset_pad_out <= 1'b0;
      soft_reset_pad_oe <= 1'b0;
    end else if (clk_en) begin
      // Power-on domain reset in hold and stretch only
      por_reset <= next_por_reset;
      // Core reset also during soft sequence; por domain untouched
      core_reset <= next_core_reset;
      run_enable <= next_run_enable;
      soft_reset_active <= next_soft_active;
      // Pad is only ever pulled low; the pull-up restores it
      soft_reset_pad_out <= 1'b0;
      soft_reset_pad_oe <= next_pad_oe;
    end
  end

endmodule

// File: verilog/rps_sync2.v
// Two-flop synchroniser for one asynchronous pin level.
// Assumes the pin is asynchronous to ref_clk; resets to RESET_VAL.
`timescale 1ns/100ps

module rps_sync2 #(
  parameter RESET_VAL = 1'b1
) (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire async_in,
  output reg sync_out
);

  reg stage1;

  // First flop feeds only the second
  always @(posedge ref_clk) begin
    if (reset) begin
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clk_en) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
